// file: inc/sbs_pkg.sv
// Package with constants and types for the SRAM boundary-scan test port.
package sbs_pkg;

    // =====================================================================
    // Sizes
    // =====================================================================
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 71;

    // =====================================================================
    // Instruction codes
    // =====================================================================
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE_LSB = 2'h1;
    localparam int TLR_ONES = 5;

    // Identification value; arbitrary neutral value, bit 0 set marks presence.
    localparam logic [ID_W-1:0] ID_VALUE = 32'h1a2b3c4d | 32'h00000001;

    // =====================================================================
    // Controller states
    // =====================================================================
    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
        ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } sbs_state_t;

endpackage

// file: rtl/sbs_sync.sv
// Two-flip-flop synchroniser for a bundle of level inputs.
`timescale 1ns/1ns
module sbs_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= '0;
            q_o <= '0;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// file: rtl/sbs_tap.sv
// Test access port of the SRAM: controller, instruction and scan paths.
//
// Contract
// [RL1] All-zero instruction decodes as the valid external-test instruction.
// [RL2] External test captures and shifts like sample, and forces SRAM outputs high-Z.
// [RL3] Identification instruction loads the fixed 32-bit value and shifts it out.
// [RL4] Instruction register becomes identification at power-up and in test-logic-reset.
// [RL5] Sample-Z puts the boundary register between data in and out in shift-DR.
// [RL6] Sample-Z holds all SRAM output drivers high impedance.
// [RL7] Sample captures input and bidirectional pin levels in capture-DR.
// [RL8] Update-DR under sample transfers nothing to pins; behaves like pause.
// [RL9] Shift-DR after sample capture shifts the captured boundary bits out.
// [RL10] Bypass in shift-DR routes data through a single bypass bit.
// [RL11] Controller never loads reserved instruction codes.
// [RL12] Controller ignores the captured clock bit if the SRAM clock runs.
// [RL13] A pin changing during capture gives an unknown bit without upset.
// [RL14] Codes: 000,001,010,100,111 used; 011,101,110 reserved.
// [RL15] Instruction register is three bits; capture-IR loads 01 into its low bits.
// [RL16] Five TMS-high rising edges reset the port without disturbing the SRAM.
// [RL17] Boundary register is 71 bits, MSB toward data in, LSB toward data out.
// [RL18] Sixteen-state controller on rising test clock; TDO driven only in shifts.
`timescale 1ns/1ns
module sbs_tap #(
    parameter int BSR_W = sbs_pkg::BSR_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [BSR_W-1:0] pins_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic sram_hiz_o
);
    // =====================================================================
    // Synchronisers and test clock edges
    // =====================================================================
    // The pins are sampled too, so a pin moving at capture only yields an
    // unknown bit value, never an unstable flop downstream.
    logic [BSR_W+2:0] sync_s;
    logic tck_s, tms_s, tdi_s;
    logic [BSR_W-1:0] pins_s;
    logic tck_prev_q;
    logic tck_rise, tck_fall;

    sbs_sync #(.W(BSR_W + 3)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({pins_i, tdi_i, tms_i, tck_i}),
        .q_o(sync_s)
    ); // RL13
    assign tck_s = sync_s[0];
    assign tms_s = sync_s[1];
    assign tdi_s = sync_s[2];
    assign pins_s = sync_s[BSR_W+2:3];

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            tck_prev_q <= 1'b0;
        else
            tck_prev_q <= tck_s;
    end
    assign tck_rise = tck_s && !tck_prev_q;
    assign tck_fall = !tck_s && tck_prev_q;

    // =====================================================================
    // Controller
    // =====================================================================
    sbs_pkg::sbs_state_t state_q, state_d;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            sbs_pkg::ST_TLR: state_d = tms_s ? sbs_pkg::ST_TLR : sbs_pkg::ST_RTI;
            sbs_pkg::ST_RTI: state_d = tms_s ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_RTI;
            sbs_pkg::ST_SEL_DR: state_d = tms_s ? sbs_pkg::ST_SEL_IR : sbs_pkg::ST_CAP_DR;
            sbs_pkg::ST_CAP_DR: state_d = tms_s ? sbs_pkg::ST_EX1_DR : sbs_pkg::ST_SH_DR;
            sbs_pkg::ST_SH_DR: state_d = tms_s ? sbs_pkg::ST_EX1_DR : sbs_pkg::ST_SH_DR;
            sbs_pkg::ST_EX1_DR: state_d = tms_s ? sbs_pkg::ST_UPD_DR : sbs_pkg::ST_PAU_DR;
            sbs_pkg::ST_PAU_DR: state_d = tms_s ? sbs_pkg::ST_EX2_DR : sbs_pkg::ST_PAU_DR;
            sbs_pkg::ST_EX2_DR: state_d = tms_s ? sbs_pkg::ST_UPD_DR : sbs_pkg::ST_SH_DR;
            sbs_pkg::ST_UPD_DR: state_d = tms_s ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_RTI;
            sbs_pkg::ST_SEL_IR: state_d = tms_s ? sbs_pkg::ST_TLR : sbs_pkg::ST_CAP_IR;
            sbs_pkg::ST_CAP_IR: state_d = tms_s ? sbs_pkg::ST_EX1_IR : sbs_pkg::ST_SH_IR;
            sbs_pkg::ST_SH_IR: state_d = tms_s ? sbs_pkg::ST_EX1_IR : sbs_pkg::ST_SH_IR;
            sbs_pkg::ST_EX1_IR: state_d = tms_s ? sbs_pkg::ST_UPD_IR : sbs_pkg::ST_PAU_IR;
            sbs_pkg::ST_PAU_IR: state_d = tms_s ? sbs_pkg::ST_EX2_IR : sbs_pkg::ST_PAU_IR;
            sbs_pkg::ST_EX2_IR: state_d = tms_s ? sbs_pkg::ST_UPD_IR : sbs_pkg::ST_SH_IR;
            sbs_pkg::ST_UPD_IR: state_d = tms_s ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_RTI;
            default: state_d = sbs_pkg::ST_TLR;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            state_q <= sbs_pkg::ST_TLR;
        else if (tck_rise)
            state_q <= state_d; // RL18 RL16
    end

    // =====================================================================
    // Instruction register
    // =====================================================================
    logic [sbs_pkg::IR_W-1:0] ir_sh_q, ir_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ir_sh_q <= sbs_pkg::INS_IDCODE;
            ir_q <= sbs_pkg::INS_IDCODE; // RL4
        end
        else if (tck_rise)
        begin
            // Loading on entry keeps the instruction right for the whole reset state.
            if (state_d == sbs_pkg::ST_TLR)
                ir_q <= sbs_pkg::INS_IDCODE; // RL4
            else if (state_q == sbs_pkg::ST_UPD_IR)
                ir_q <= ir_sh_q;
            if (state_q == sbs_pkg::ST_CAP_IR)
                ir_sh_q <= {1'b0, sbs_pkg::IR_CAPTURE_LSB}; // RL15
            else if (state_q == sbs_pkg::ST_SH_IR)
                ir_sh_q <= {tdi_s, ir_sh_q[sbs_pkg::IR_W-1:1]};
        end
    end

    // Decode; reserved codes fall back to the bypass path as a safe choice.
    logic sel_bsr, sel_id;
    assign sel_bsr = (ir_q == sbs_pkg::INS_EXTEST) || (ir_q == sbs_pkg::INS_SAMPLE_Z)
        || (ir_q == sbs_pkg::INS_SAMPLE); // RL1 RL2 RL5 RL9 RL14
    assign sel_id = (ir_q == sbs_pkg::INS_IDCODE); // RL3

    // =====================================================================
    // Data registers
    // =====================================================================
    logic [BSR_W-1:0] bsr_q;
    logic [sbs_pkg::ID_W-1:0] id_q;
    logic byp_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            bsr_q <= '0;
            id_q <= '0;
            byp_q <= 1'b0;
        end
        else if (tck_rise)
        begin
            if (state_q == sbs_pkg::ST_CAP_DR)
            begin
                if (sel_bsr)
                    bsr_q <= pins_s; // RL7 RL2
                if (sel_id)
                    id_q <= sbs_pkg::ID_VALUE; // RL3
                byp_q <= 1'b0;
            end
            else if (state_q == sbs_pkg::ST_SH_DR)
            begin
                if (sel_bsr)
                    bsr_q <= {tdi_s, bsr_q[BSR_W-1:1]}; // RL17 RL9
                else if (sel_id)
                    id_q <= {tdi_s, id_q[sbs_pkg::ID_W-1:1]}; // RL3
                else
                    byp_q <= tdi_s; // RL10
            end
            // Update-DR holds everything, like Pause-DR; nothing reaches the pins.
        end
    end // RL8

    // =====================================================================
    // Outputs
    // =====================================================================
    logic tdo_q, tdo_oe_q, hiz_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_oe_q <= (state_q == sbs_pkg::ST_SH_IR) || (state_q == sbs_pkg::ST_SH_DR); // RL18
            if (state_q == sbs_pkg::ST_SH_IR)
                tdo_q <= ir_sh_q[0];
            else if (sel_bsr)
                tdo_q <= bsr_q[0]; // RL17
            else if (sel_id)
                tdo_q <= id_q[0];
            else
                tdo_q <= byp_q; // RL10
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            hiz_q <= 1'b0;
        else
            hiz_q <= (ir_q == sbs_pkg::INS_EXTEST) || (ir_q == sbs_pkg::INS_SAMPLE_Z); // RL2 RL6
    end

    assign tdo_o = tdo_q;
    assign tdo_oe_o = tdo_oe_q;
    assign sram_hiz_o = hiz_q;

    // =====================================================================
    // Checks
    // =====================================================================
    // Run of TMS-high rises, saturating one below the count that must force the reset state.
    logic [2:0] hi_cnt_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            hi_cnt_q <= 3'h0;
        else if (tck_rise && !tms_s)
            hi_cnt_q <= 3'h0;
        else if (tck_rise && hi_cnt_q != 3'(sbs_pkg::TLR_ONES - 1))
            hi_cnt_q <= hi_cnt_q + 3'h1;
    end

    sequence s_five_high;
        tck_rise && tms_s && hi_cnt_q == 3'(sbs_pkg::TLR_ONES - 1);
    endsequence

    AST_TLR_IDCODE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL4
        state_q == sbs_pkg::ST_TLR |-> ir_q == sbs_pkg::INS_IDCODE)
        else $error("Instruction not IDCODE in reset state.");
    AST_CAP_IR: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL15
        (tck_rise && state_q == sbs_pkg::ST_CAP_IR) |=> ir_sh_q[1:0] == sbs_pkg::IR_CAPTURE_LSB)
        else $error("Capture-IR did not load 01.");
    AST_HIZ: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL6
        (ir_q == sbs_pkg::INS_SAMPLE_Z && $stable(ir_q)) |=> sram_hiz_o)
        else $error("Outputs not forced high-Z under SAMPLE Z.");
    AST_EXT_HIZ: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
        (ir_q == sbs_pkg::INS_EXTEST && $stable(ir_q)) |=> sram_hiz_o)
        else $error("Outputs not forced high-Z under EXTEST.");
    AST_NO_HIZ: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
        (ir_q == sbs_pkg::INS_SAMPLE && $stable(ir_q)) |=> !sram_hiz_o)
        else $error("SAMPLE forced high-Z.");
    AST_ID_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL3
        (tck_rise && sel_id && state_q == sbs_pkg::ST_CAP_DR) |=> id_q == sbs_pkg::ID_VALUE)
        else $error("ID value not captured.");
    AST_BSR_CAP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL7 RL1
        (tck_rise && state_q == sbs_pkg::ST_CAP_DR && (ir_q == sbs_pkg::INS_EXTEST
        || ir_q == sbs_pkg::INS_SAMPLE_Z || ir_q == sbs_pkg::INS_SAMPLE))
        |=> bsr_q == $past(pins_s))
        else $error("Boundary capture wrong.");
    AST_UPD_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL8
        (tck_rise && state_q == sbs_pkg::ST_UPD_DR) |=> $stable(bsr_q) && $stable(sram_hiz_o))
        else $error("Update-DR changed boundary state.");
    AST_TDO_OE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL18
        (tck_fall && state_q != sbs_pkg::ST_SH_IR && state_q != sbs_pkg::ST_SH_DR)
        |=> !tdo_oe_o)
        else $error("TDO driven outside shift.");
    AST_BYP: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL10
        (tck_rise && ir_q == sbs_pkg::INS_BYPASS && state_q == sbs_pkg::ST_SH_DR)
        |=> byp_q == $past(tdi_s))
        else $error("Bypass bit did not take TDI.");
    AST_FIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL16
        s_five_high |=> state_q == sbs_pkg::ST_TLR)
        else $error("Five TMS-high rises did not reach the reset state.");
endmodule

// file: tb/sbs_host_model.sv
// Boundary-scan controller model that drives the test pins of the port.
`timescale 1ns/1ns
module sbs_host_model (
    input wire logic clk_i,
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    // =========================================================
    // Pin drive
    // =========================================================
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // One test-clock period of 800 ns. The clock rests low between frames.
    // TDO is taken just before the rise; an undriven TDO reads as unknown.
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        repeat (4) @(posedge clk_i);
        #1;
        tdo = tdo_oe_i ? tdo_i : 1'bx;
        tck_o = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        tck_o = 1'b0;
    endtask

    // Five high mode bits, then one low bit to reach Run-Test/Idle.
    task automatic reset5();
        logic d;
        repeat (5) step(1'b1, ~tdi_o, d);
        step(1'b0, ~tdi_o, d);
    endtask

    // From Run-Test/Idle, scan n bits LSB first and return to Run-Test/Idle.
    // Unused data-in bits toggle so a stale level cannot pass for data.
    task automatic scan(input logic ir, input int n, input logic [79:0] din,
        output logic [79:0] dout);
        logic d;
        dout = '0;
        step(1'b1, ~tdi_o, d);
        if (ir)
            step(1'b1, ~tdi_o, d);
        step(1'b0, ~tdi_o, d);
        step(1'b0, ~tdi_o, d);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        step(1'b1, ~tdi_o, d);
        step(1'b0, ~tdi_o, d);
    endtask
endmodule

// file: tb/sbs_tap_tb.sv
// Self-checking bench for the SRAM boundary-scan test port.
`timescale 1ns/1ns
module sbs_tap_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [sbs_pkg::BSR_W-1:0] pins_i = 71'h4d_1234_5678_9abc_def0;
    logic tck, tms, tdi, tdo_o, tdo_oe_o, sram_hiz_o;
    logic [79:0] got, din;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    // Legal codes only: a controller never loads the reserved ones.
    logic [2:0] row_code [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h2, 3'h0, 3'h4};
    int row_len [8] = '{71, 32, 71, 71, 1, 71, 71, 71};
    logic row_hiz [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

    sbs_tap #(.BSR_W(sbs_pkg::BSR_W)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .pins_i(pins_i), .tdo_o(tdo_o),
        .tdo_oe_o(tdo_oe_o), .sram_hiz_o(sram_hiz_o));
    sbs_host_model i_host (.clk_i(clk_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o),
        .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

    // =========================================================
    // Clock, timeout and reporting
    // =========================================================
    always #50 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check_bits(input logic [79:0] g, input logic [79:0] e, input string m);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask

    task automatic check_bit(input logic g, input logic e, input string m);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: %s got %b expected %b", $time, m, g, e);
        end
    endtask

    // Captured bits come out first, then the bits shifted in after them.
    function automatic logic [79:0] expect_out(input int len, input logic [79:0] din);
        logic [79:0] cap;
        cap = (len == 32) ? {48'h0, sbs_pkg::ID_VALUE} : (len == 71) ? {9'h0, pins_i} : '0;
        return (din << len) | (cap & ((80'h1 << len) - 80'h1));
    endfunction

    // =========================================================
    // Main sequence
    // =========================================================
    initial
    begin
        repeat (12) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        i_host.reset5();
        din = {5{16'h3c5a}};
        i_host.scan(1'b0, 80, din, got);
        check_bits(got, expect_out(32, din), "power-up id");
        // Every legal code; pins change only between scans, never across a capture.
        for (int r = 0; r < 8; r++)
        begin
            pins_i = ~pins_i;
            i_host.scan(1'b1, sbs_pkg::IR_W, {77'h0, row_code[r]}, got);
            check_bits(got & 80'h3, {78'h0, sbs_pkg::IR_CAPTURE_LSB}, "capture-ir");
            check_bit(sram_hiz_o, row_hiz[r], "high-z after update-ir");
            din = {5{16'h96c3}} ^ 80'(r);
            i_host.scan(1'b0, 80, din, got);
            check_bits(got, expect_out(row_len[r], din), "dr scan");
            check_bit(sram_hiz_o, row_hiz[r], "high-z after update-dr");
            check_bit(tdo_oe_o, 1'b0, "tdo idle");
        end
        // Five high mode bits leave sample and restore identification.
        i_host.reset5();
        check_bit(sram_hiz_o, 1'b0, "high-z after tap reset");
        i_host.scan(1'b0, 80, din, got);
        check_bits(got, expect_out(32, din), "id after tap reset");
        // External test active, then a system reset in mid-run.
        i_host.scan(1'b1, sbs_pkg::IR_W, {77'h0, sbs_pkg::INS_EXTEST}, got);
        check_bit(sram_hiz_o, 1'b1, "extest high-z");
        rst_n_i = 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        check_bit(sram_hiz_o, 1'b0, "high-z in reset");
        check_bit(tdo_oe_o, 1'b0, "tdo in reset");
        rst_n_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        i_host.reset5();
        i_host.scan(1'b0, 80, din, got);
        check_bits(got, expect_out(32, din), "id after reset");
        conclude();
    end
endmodule
